// file: printer_pkg.sv
package printer_pkg;

  localparam logic [7:0] ADDR_CONFIG = 8'h00;
  localparam logic [7:0] ADDR_CONTROL = 8'h04;
  localparam logic [7:0] ADDR_STATUS = 8'h08;
  localparam logic [7:0] ADDR_TEXT = 8'h0C;
  localparam logic [7:0] ADDR_VAR = 8'h10;
  localparam logic [7:0] ADDR_SEQ_DATA = 8'h14;
  localparam logic [7:0] ADDR_SEQ_LEN = 8'h18;
  localparam logic [7:0] ADDR_LINE = 8'h1C;

  localparam int CTRL_START = 0;
  localparam int CTRL_END_VAR = 1;
  localparam int CTRL_DEFAULTS = 2;
  localparam int STAT_TEXT_READY = 0;
  localparam int STAT_VAR_REQ = 1;
  localparam int STAT_PAUSED = 2;
  localparam int STAT_OVERFLOW = 3;
  localparam int STAT_BUSY = 4;
  localparam int STAT_CTS = 5;
  localparam int STAT_DROP = 6;
  localparam int TEXT_TAG_BIT = 8;
  localparam int SEQ_POS_LSB = 8;
  localparam int SEQ_SEL_LSB = 16;
  localparam int CFG_WIDTH = 10;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  localparam int NUM_BAUDS = 7;
  localparam int BAUD_RATE [NUM_BAUDS] = '{300, 600, 1200, 2400, 4800, 9600, 19200};
  localparam logic [2:0] BAUD_DEFAULT = 3'h5;

  localparam logic [1:0] PARITY_NONE = 2'h0;
  localparam logic [1:0] PARITY_ODD = 2'h1;
  localparam logic [1:0] PARITY_EVEN = 2'h2;
  localparam logic [1:0] HS_RTS_CTS = 2'h0;
  localparam logic [1:0] HS_SOFT = 2'h1;
  localparam logic [1:0] HS_WAIT_FIRST = 2'h2;

  typedef struct packed {
    logic lang;
    logic [1:0] handshake;
    logic two_stop;
    logic [1:0] parity;
    logic eight_bits;
    logic [2:0] baud;
  } cfg_type;

  localparam cfg_type CFG_DEFAULT = '{lang: 1'b0, handshake: HS_RTS_CTS, two_stop: 1'b0,
    parity: PARITY_NONE, eight_bits: 1'b1, baud: BAUD_DEFAULT};

  localparam logic [7:0] CH_HASH = 8'h23;
  localparam logic [7:0] CH_DOLLAR = 8'h24;
  localparam logic [7:0] CH_AT = 8'h40;
  localparam logic [7:0] CH_NL = 8'h0A;
  localparam logic [7:0] CH_CR = 8'h0D;
  localparam logic [7:0] CH_ONE = 8'h31;
  localparam logic [7:0] CH_EIGHT = 8'h38;
  localparam logic [7:0] CH_XON = 8'h11;
  localparam logic [7:0] CH_XOFF = 8'h13;

  localparam int NUM_SEQ = 9;
  localparam int SEQ_BYTES = 80;
  localparam logic [6:0] EOL_DEFAULT_LEN = 7'h02;
  localparam logic [6:0] MAX_LINES = 7'h7E;
  localparam logic [7:0] MAX_CHARS = 8'h84;
  localparam logic [3:0] MAX_VARS = 4'h8;

  typedef enum logic [6:0] {
    S_IDLE = 7'b0000001,
    S_MARK = 7'b0000010,
    S_HEX1 = 7'b0000100,
    S_HEX2 = 7'b0001000,
    S_SEQ = 7'b0010000,
    S_NAME = 7'b0100000,
    S_VAR = 7'b1000000
  } engine_state_type;

endpackage : printer_pkg

// file: byte_fifo.sv
`timescale 1ns/1ps
`default_nettype none
module byte_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic in_valid,
  input wire logic [WIDTH-1:0] in_data,
  output logic in_ready,
  output logic out_valid,
  output logic [WIDTH-1:0] out_data,
  input wire logic out_ready
);
  localparam int AW = $clog2(DEPTH);

  if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
    $error("depth must be a power of two, at least 2");
  end

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wr_ptr;
  logic [AW:0] rd_ptr;

  assign in_ready = (wr_ptr ^ rd_ptr) != {1'b1, {AW{1'b0}}};
  assign out_valid = wr_ptr != rd_ptr;
  assign out_data = mem[rd_ptr[AW-1:0]];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wr_ptr <= '0;
    end else if (in_valid && in_ready) begin
      mem[wr_ptr[AW-1:0]] <= in_data;
      wr_ptr <= wr_ptr + 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rd_ptr <= '0;
    end else if (out_valid && out_ready) begin
      rd_ptr <= rd_ptr + 1'b1;
    end
  end
endmodule : byte_fifo
`default_nettype wire

// file: serial_port.sv
`timescale 1ns/1ps
`default_nettype none
module serial_port #(
  parameter int CLK_HZ = 40000000
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire printer_pkg::cfg_type cfg,
  input wire logic in_valid,
  input wire logic [7:0] in_data,
  output logic in_ready,
  input wire logic allowed,
  input wire logic rxd,
  output logic txd,
  output logic rx_valid,
  output logic [7:0] rx_data,
  output logic busy
);
  if (CLK_HZ / 300 >= (1 << 18) || CLK_HZ / 19200 < 2) begin : g_bad_clk
    $error("clock rate outside divider range");
  end

  logic [17:0] div_tab [printer_pkg::NUM_BAUDS];
  for (genvar g = 0; g < printer_pkg::NUM_BAUDS; g++) begin : g_div
    assign div_tab[g] = 18'(CLK_HZ / printer_pkg::BAUD_RATE[g]);
  end

  logic [17:0] div;
  logic [3:0] nd;
  logic [3:0] last;
  assign div = (cfg.baud <= 3'h6) ? div_tab[cfg.baud] : div_tab[printer_pkg::BAUD_DEFAULT];
  assign nd = cfg.eight_bits ? 4'h8 : 4'h7;
  assign last = nd + 4'(cfg.parity != printer_pkg::PARITY_NONE) + 4'h1;

  // start bit low, data lsb first, optional parity, stop bits high
  function automatic logic [11:0] build(input logic [7:0] d, input printer_pkg::cfg_type c);
    logic [11:0] f;
    logic [7:0] dm;
    int n;
    f = 12'hFFF;
    f[0] = 1'b0;
    n = c.eight_bits ? 8 : 7;
    dm = c.eight_bits ? d : {1'b0, d[6:0]};
    for (int i = 0; i < 8; i++) begin
      if (i < n) f[1+i] = d[i];
    end
    if (c.parity != printer_pkg::PARITY_NONE)
      f[1+n] = (^dm) ^ (c.parity == printer_pkg::PARITY_ODD);
    return f;
  endfunction : build

  logic [11:0] frame;
  logic [11:0] built;
  logic [3:0] bits_left;
  assign built = build(in_data, cfg);
  logic [17:0] tx_cnt;

  assign in_ready = (bits_left == 4'h0) && allowed;
  assign busy = bits_left != 4'h0;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      txd <= 1'b1; // see RULE14
      frame <= 12'hFFF;
      bits_left <= 4'h0;
      tx_cnt <= '0;
    end else if (bits_left == 4'h0) begin
      if (in_valid && allowed) begin
        frame <= {1'b1, built[11:1]}; // see RULE2
        txd <= 1'b0; // see RULE14
        // extra shift keeps the last stop bit a full bit time
        bits_left <= last + 4'(cfg.two_stop) + 4'h1;
        tx_cnt <= div - 18'h1; // see RULE1
      end
    end else if (tx_cnt == '0) begin
      txd <= frame[0];
      frame <= {1'b1, frame[11:1]};
      bits_left <= bits_left - 4'h1;
      tx_cnt <= div - 18'h1;
    end else begin
      tx_cnt <= tx_cnt - 18'h1;
    end
  end

  logic rx_s1;
  logic rx_s2;
  logic rx_s3;
  logic rx_lvl;
  logic rx_active;
  logic [3:0] rx_idx;
  logic [17:0] rx_cnt;
  logic [7:0] rx_byte;

  always_ff @(posedge aclk) begin
    rx_s1 <= rxd;
    rx_s2 <= rx_s1;
    rx_s3 <= rx_s2;
    if (!aresetn) rx_lvl <= 1'b1;
    else if (rx_s2 == rx_s3) rx_lvl <= rx_s3;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rx_active <= 1'b0;
      rx_idx <= 4'h0;
      rx_cnt <= '0;
      rx_byte <= 8'h00;
      rx_valid <= 1'b0;
      rx_data <= 8'h00;
    end else begin
      rx_valid <= 1'b0;
      if (!rx_active) begin
        if (!rx_lvl) begin
          rx_active <= 1'b1;
          rx_idx <= 4'h0;
          rx_cnt <= div >> 1;
          rx_byte <= 8'h00;
        end
      end else if (rx_cnt != '0) begin
        rx_cnt <= rx_cnt - 18'h1;
      end else begin
        rx_cnt <= div - 18'h1;
        rx_idx <= rx_idx + 4'h1;
        if (rx_idx == 4'h0 && rx_lvl) rx_active <= 1'b0;
        if (rx_idx != 4'h0 && rx_idx <= nd) rx_byte[3'(rx_idx - 4'h1)] <= rx_lvl;
        if (rx_idx == last) begin
          rx_active <= 1'b0;
          rx_valid <= rx_lvl;
          rx_data <= rx_byte;
        end
      end
    end
  end
endmodule : serial_port
`default_nettype wire

// file: printer_serial_output.sv
// Overview of operation
// RULE1 - baud 300 to 19200 selectable, 9600 after defaults
// RULE2 - 7 or 8 data bits, none/odd/even parity, 1 or 2 stop bits
// RULE3 - hardware handshake: hold transmission while printer not ready or absent
// RULE4 - plain soft handshake: send at once until xoff; unheard data is lost
// RULE5 - wait-first soft handshake: await xon before page, stop on xoff
// RULE6 - after every line send end-of-line sequence, default cr lf
// RULE7 - empty end-of-line sequence appends nothing at line ends
// RULE8 - eight stored control sequences of up to 80 bytes replace markers
// RULE9 - dollar plus two hex digits becomes one raw byte
// RULE10 - name between at-signs replaced by the variable's current value
// RULE11 - language selector 0 prints first text, 1 the second
// RULE12 - interface settings kept across power cycles in backed storage
// RULE13 - page limited to 126 lines, 132 characters, 8 variables per line
// RULE14 - idle mark, one start bit, data least significant bit first
// RULE15 - printer pauses with xoff 13h and resumes with xon 11h
`timescale 1ns/1ps
`default_nettype none
module printer_serial_output #(
  parameter int CLK_HZ = 40000000,
  parameter int FIFO_DEPTH = 32
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  output logic txd,
  input wire logic rxd,
  input wire logic cts_n,
  output logic rts_n,
  input wire logic backup_ok
);

  logic [7:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic wr_fire;
  logic wr_ok;
  logic [31:0] rd_data;
  logic rd_ok;

  // write channel: address and data taken in either order
  assign wr_fire = !awready && !wready && !bvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready <= 1'b1;
      wready <= 1'b1;
      bvalid <= 1'b0;
      bresp <= printer_pkg::RESP_OKAY;
      aw_addr <= 8'h00;
      w_data <= 32'h00000000;
      w_strb <= 4'h0;
    end else begin
      if (awvalid && awready) begin
        aw_addr <= awaddr;
        awready <= 1'b0;
      end
      if (wvalid && wready) begin
        w_data <= wdata;
        w_strb <= wstrb;
        wready <= 1'b0;
      end
      if (wr_fire) begin
        bvalid <= 1'b1;
        bresp <= wr_ok ? printer_pkg::RESP_OKAY : printer_pkg::RESP_SLVERR;
      end
      if (bvalid && bready) begin
        bvalid <= 1'b0;
        awready <= 1'b1;
        wready <= 1'b1;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready <= 1'b1;
      rvalid <= 1'b0;
      rdata <= 32'h00000000;
      rresp <= printer_pkg::RESP_OKAY;
    end else if (arvalid && arready) begin
      arready <= 1'b0;
      rvalid <= 1'b1;
      rdata <= rd_data;
      rresp <= rd_ok ? printer_pkg::RESP_OKAY : printer_pkg::RESP_SLVERR;
    end else if (rvalid && rready) begin
      rvalid <= 1'b0;
      arready <= 1'b1;
    end
  end

  logic wr_cfg;
  logic wr_ctrl;
  logic wr_stat;
  logic wr_text;
  logic wr_var;
  logic wr_seq_data;
  logic wr_seq_len;
  assign wr_ok = aw_addr inside {printer_pkg::ADDR_CONFIG, printer_pkg::ADDR_CONTROL,
    printer_pkg::ADDR_STATUS, printer_pkg::ADDR_TEXT, printer_pkg::ADDR_VAR,
    printer_pkg::ADDR_SEQ_DATA, printer_pkg::ADDR_SEQ_LEN};
  assign wr_cfg = wr_fire && aw_addr == printer_pkg::ADDR_CONFIG;
  assign wr_ctrl = wr_fire && w_strb[0] && aw_addr == printer_pkg::ADDR_CONTROL;
  assign wr_stat = wr_fire && w_strb[0] && aw_addr == printer_pkg::ADDR_STATUS;
  assign wr_text = wr_fire && w_strb[0] && aw_addr == printer_pkg::ADDR_TEXT;
  assign wr_var = wr_fire && w_strb[0] && aw_addr == printer_pkg::ADDR_VAR;
  assign wr_seq_data = wr_fire && w_strb[0] && aw_addr == printer_pkg::ADDR_SEQ_DATA;
  assign wr_seq_len = wr_fire && w_strb[0] && aw_addr == printer_pkg::ADDR_SEQ_LEN;

  logic start_page;
  logic end_var;
  assign start_page = wr_ctrl && w_data[printer_pkg::CTRL_START];
  assign end_var = wr_ctrl && w_data[printer_pkg::CTRL_END_VAR];

  // pin synchronisers: cts_n and backup_ok
  logic [1:0] pin_s1;
  logic [1:0] pin_s2;
  logic [1:0] pin_s3;
  logic [1:0] pin_lvl;
  always_ff @(posedge aclk) begin
    pin_s1 <= {backup_ok, cts_n};
    pin_s2 <= pin_s1;
    pin_s3 <= pin_s2;
    pin_lvl <= (pin_lvl & (pin_s2 ^ pin_s3)) | (pin_s3 & ~(pin_s2 ^ pin_s3));
  end

  // settings survive reset while the backup supply holds
  printer_pkg::cfg_type cfg;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      case (pin_lvl[1]) // unsettled or low backup level restores defaults
        1'b1: cfg <= cfg; // see RULE12
        default: cfg <= printer_pkg::CFG_DEFAULT;
      endcase
    end else if (wr_ctrl && w_data[printer_pkg::CTRL_DEFAULTS]) begin
      cfg <= printer_pkg::CFG_DEFAULT; // see RULE1
    end else if (wr_cfg) begin
      if (w_strb[0]) cfg[7:0] <= w_data[7:0]; // see RULE2
      if (w_strb[1]) cfg[9:8] <= w_data[9:8];
    end
  end

  logic [7:0] seq_mem [printer_pkg::NUM_SEQ][printer_pkg::SEQ_BYTES];
  logic [6:0] seq_len [printer_pkg::NUM_SEQ];
  logic [3:0] ws_sel;
  logic [6:0] ws_pos;
  assign ws_sel = w_data[printer_pkg::SEQ_SEL_LSB +: 4];
  assign ws_pos = w_data[printer_pkg::SEQ_POS_LSB +: 7];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int i = 0; i < printer_pkg::NUM_SEQ; i++) seq_len[i] <= 7'h00;
      seq_len[0] <= printer_pkg::EOL_DEFAULT_LEN; // see RULE6
      seq_mem[0][0] <= printer_pkg::CH_CR;
      seq_mem[0][1] <= printer_pkg::CH_NL;
    end else begin
      if (wr_seq_data && ws_sel < 4'(printer_pkg::NUM_SEQ) && ws_pos < 7'(printer_pkg::SEQ_BYTES))
        seq_mem[ws_sel][ws_pos] <= w_data[7:0]; // see RULE8
      if (wr_seq_len && ws_sel < 4'(printer_pkg::NUM_SEQ)
        && w_data[6:0] <= 7'(printer_pkg::SEQ_BYTES))
        seq_len[ws_sel] <= w_data[6:0];
    end
  end

  // one-byte text holding register
  logic text_full;
  logic [7:0] text_byte;
  logic text_tag;
  logic text_raw;
  logic drop_err;
  logic take;
  logic txt;
  logic push_valid;
  logic [7:0] push_data;
  logic fifo_in_ready;
  logic stall;
  printer_pkg::engine_state_type state;

  assign stall = push_valid && !fifo_in_ready;
  assign take = text_full && !stall && state != printer_pkg::S_SEQ
    && !(state == printer_pkg::S_VAR && !text_raw);
  assign txt = take && !text_raw && text_tag == cfg.lang; // see RULE11

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      text_full <= 1'b0;
      text_byte <= 8'h00;
      text_tag <= 1'b0;
      text_raw <= 1'b0;
      drop_err <= 1'b0;
    end else begin
      if (take) text_full <= 1'b0;
      if (wr_stat && w_data[printer_pkg::STAT_DROP]) drop_err <= 1'b0;
      if (wr_text || wr_var) begin
        if (text_full) begin
          drop_err <= 1'b1;
        end else begin
          text_full <= 1'b1;
          text_byte <= w_data[7:0];
          text_tag <= wr_text && w_data[printer_pkg::TEXT_TAG_BIT];
          text_raw <= wr_var;
        end
      end
    end
  end

  logic [4:0] hex_nib;
  always_comb begin
    hex_nib = 5'h00;
    if (text_byte >= 8'h30 && text_byte <= 8'h39) hex_nib = {1'b1, text_byte[3:0]};
    else if ((text_byte | 8'h20) >= 8'h61 && (text_byte | 8'h20) <= 8'h66)
      hex_nib = {1'b1, 4'(text_byte[3:0] + 4'h9)};
  end

  logic [3:0] hex_hi;
  logic [3:0] seq_sel;
  logic [6:0] seq_pos;
  logic [31:0] var_name;
  logic [3:0] var_cnt;
  logic plain;
  logic line_end;
  assign plain = state == printer_pkg::S_IDLE && txt && !(text_byte inside
    {printer_pkg::CH_HASH, printer_pkg::CH_DOLLAR, printer_pkg::CH_AT, printer_pkg::CH_NL});
  assign line_end = state == printer_pkg::S_IDLE && txt && text_byte == printer_pkg::CH_NL;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state <= printer_pkg::S_IDLE;
      hex_hi <= 4'h0;
      seq_sel <= 4'h0;
      seq_pos <= 7'h00;
      var_name <= 32'h00000000;
    end else if (start_page) begin
      state <= printer_pkg::S_IDLE;
    end else if (!stall) begin
      unique case (state)
        printer_pkg::S_IDLE: begin
          seq_pos <= 7'h00;
          seq_sel <= 4'h0;
          if (txt && text_byte == printer_pkg::CH_HASH) state <= printer_pkg::S_MARK;
          if (txt && text_byte == printer_pkg::CH_DOLLAR) state <= printer_pkg::S_HEX1;
          if (txt && text_byte == printer_pkg::CH_AT) begin
            var_name <= 32'h00000000;
            state <= printer_pkg::S_NAME; // see RULE10
          end
          if (line_end && seq_len[0] != 7'h00) state <= printer_pkg::S_SEQ; // see RULE6, RULE7
        end
        printer_pkg::S_MARK: if (txt) begin
          seq_sel <= 4'(text_byte - 8'h30);
          state <= (text_byte >= printer_pkg::CH_ONE && text_byte <= printer_pkg::CH_EIGHT
            && seq_len[4'(text_byte - 8'h30)] != 7'h00) ? printer_pkg::S_SEQ
            : printer_pkg::S_IDLE; // see RULE8
        end
        printer_pkg::S_HEX1: if (txt) begin
          hex_hi <= hex_nib[3:0];
          state <= hex_nib[4] ? printer_pkg::S_HEX2 : printer_pkg::S_IDLE; // see RULE9
        end
        printer_pkg::S_HEX2: if (txt) state <= printer_pkg::S_IDLE;
        printer_pkg::S_SEQ: begin
          seq_pos <= seq_pos + 7'h01;
          if (seq_pos == seq_len[seq_sel] - 7'h01) state <= printer_pkg::S_IDLE;
        end
        printer_pkg::S_NAME: if (txt) begin
          if (text_byte != printer_pkg::CH_AT) var_name <= {var_name[23:0], text_byte};
          else state <= (var_cnt < printer_pkg::MAX_VARS) ? printer_pkg::S_VAR
            : printer_pkg::S_IDLE; // see RULE13
        end
        printer_pkg::S_VAR: if (end_var) state <= printer_pkg::S_IDLE;
      endcase
    end
  end

  // byte emission, line and variable accounting
  logic text_emit;
  logic [7:0] emit_byte;
  logic [6:0] line_cnt;
  logic [7:0] char_cnt;
  logic overflow;
  assign text_emit = plain || (state == printer_pkg::S_HEX2 && txt && hex_nib[4])
    || (state == printer_pkg::S_VAR && take);
  assign emit_byte = (state == printer_pkg::S_HEX2) ? {hex_hi, hex_nib[3:0]} : text_byte;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      push_valid <= 1'b0;
      push_data <= 8'h00;
      line_cnt <= 7'h00;
      char_cnt <= 8'h00;
      var_cnt <= 4'h0;
      overflow <= 1'b0;
    end else begin
      if (!stall) push_valid <= 1'b0;
      if (wr_stat && w_data[printer_pkg::STAT_OVERFLOW]) overflow <= 1'b0;
      if (start_page) begin
        line_cnt <= 7'h00;
        char_cnt <= 8'h00;
        var_cnt <= 4'h0;
      end else if (!stall) begin
        if (state == printer_pkg::S_SEQ) begin
          push_valid <= 1'b1;
          push_data <= seq_mem[seq_sel][seq_pos]; // see RULE8
        end else if (text_emit) begin
          if (char_cnt < printer_pkg::MAX_CHARS && line_cnt < printer_pkg::MAX_LINES) begin
            push_valid <= 1'b1;
            push_data <= emit_byte; // see RULE9
            char_cnt <= char_cnt + 8'h01;
          end else begin
            overflow <= 1'b1; // see RULE13
          end
        end
        if (line_end) begin
          if (line_cnt < printer_pkg::MAX_LINES) line_cnt <= line_cnt + 7'h01;
          char_cnt <= 8'h00;
          var_cnt <= 4'h0;
        end
        if (state == printer_pkg::S_NAME && txt && text_byte == printer_pkg::CH_AT) begin
          if (var_cnt < printer_pkg::MAX_VARS) var_cnt <= var_cnt + 4'h1;
          else overflow <= 1'b1; // see RULE13
        end
      end
    end
  end

  logic fifo_out_valid;
  logic [7:0] fifo_out_data;
  logic tx_ready;
  logic tx_allowed;
  logic tx_busy;
  logic rx_valid;
  logic [7:0] rx_data;
  logic paused;

  byte_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_fifo (
    .aclk(aclk),
    .aresetn(aresetn),
    .in_valid(push_valid),
    .in_data(push_data),
    .in_ready(fifo_in_ready),
    .out_valid(fifo_out_valid),
    .out_data(fifo_out_data),
    .out_ready(tx_ready)
  );

  // flow control by handshake style
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      paused <= 1'b0;
      rts_n <= 1'b1;
    end else begin
      rts_n <= 1'b0;
      if (start_page) paused <= cfg.handshake == printer_pkg::HS_WAIT_FIRST; // see RULE4, RULE5
      if (rx_valid && rx_data == printer_pkg::CH_XOFF) paused <= 1'b1; // see RULE15
      if (rx_valid && rx_data == printer_pkg::CH_XON) paused <= 1'b0; // see RULE5
    end
  end

  assign tx_allowed = (cfg.handshake == printer_pkg::HS_RTS_CTS) ? !pin_lvl[0]
    : !paused; // see RULE3, RULE4

  serial_port #(.CLK_HZ(CLK_HZ)) u_port (
    .aclk(aclk),
    .aresetn(aresetn),
    .cfg(cfg),
    .in_valid(fifo_out_valid),
    .in_data(fifo_out_data),
    .in_ready(tx_ready),
    .allowed(tx_allowed),
    .rxd(rxd),
    .txd(txd),
    .rx_valid(rx_valid),
    .rx_data(rx_data),
    .busy(tx_busy)
  );

  always_comb begin
    rd_data = 32'h00000000;
    rd_ok = 1'b1;
    unique case (araddr)
      printer_pkg::ADDR_CONFIG: rd_data = 32'(cfg);
      printer_pkg::ADDR_CONTROL: rd_data = 32'h00000000;
      printer_pkg::ADDR_STATUS: begin
        rd_data[printer_pkg::STAT_TEXT_READY] = !text_full;
        rd_data[printer_pkg::STAT_VAR_REQ] = state == printer_pkg::S_VAR;
        rd_data[printer_pkg::STAT_PAUSED] = paused;
        rd_data[printer_pkg::STAT_OVERFLOW] = overflow;
        rd_data[printer_pkg::STAT_BUSY] = state != printer_pkg::S_IDLE || text_full
          || push_valid || fifo_out_valid || tx_busy;
        rd_data[printer_pkg::STAT_CTS] = !pin_lvl[0];
        rd_data[printer_pkg::STAT_DROP] = drop_err;
      end
      printer_pkg::ADDR_TEXT: rd_data = 32'h00000000;
      printer_pkg::ADDR_VAR: rd_data = var_name;
      printer_pkg::ADDR_SEQ_DATA: rd_data = 32'h00000000;
      printer_pkg::ADDR_SEQ_LEN: rd_data = {25'h0000000, seq_len[0]};
      printer_pkg::ADDR_LINE: rd_data = {16'h0000, char_cnt, 1'b0, line_cnt};
      default: rd_ok = 1'b0;
    endcase
  end
endmodule : printer_serial_output
`default_nettype wire

// file: printer_serial_output_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module psout_checker (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic awvalid,
  input wire logic awready,
  input wire logic wvalid,
  input wire logic wready,
  input wire logic [1:0] bresp,
  input wire logic bvalid,
  input wire logic bready,
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  input wire logic arready,
  input wire logic [31:0] rdata,
  input wire logic [1:0] rresp,
  input wire logic rvalid,
  input wire logic rready,
  input wire logic txd,
  input wire logic rts_n
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_wr_taken;
    awvalid && awready && wvalid && wready;
  endsequence
  sequence s_start_bit;
    !txd [*8];
  endsequence
  a_b_answer: assert property (s_wr_taken |-> ##2 bvalid)
    else $error("write response late");
  a_b_hold: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write response dropped");
  a_ready_low: assert property (bvalid |-> !awready && !wready)
    else $error("write ready during response");
  a_r_answer: assert property (arvalid && arready |=> rvalid)
    else $error("read response late");
  a_r_hold: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
    else $error("read data dropped");
  a_read_err: assert property (arvalid && arready && araddr > 8'h1C |=>
    rresp == printer_pkg::RESP_SLVERR && rdata == 32'h0) else $error("unmapped read");
  a_start_bit: assert property ($fell(txd) |-> s_start_bit)
    else $error("start bit short");
  a_rts_on: assert property ($rose(aresetn) |-> ##2 !rts_n [*8])
    else $error("rts not asserted");
endmodule : psout_checker
bind printer_serial_output psout_checker chk (.*);
`default_nettype wire

// file: printer_model.sv
`timescale 1ns/1ps
`default_nettype none
module printer_model #(
  parameter int BIT = 20
) (
  input wire logic aclk,
  input wire logic txd,
  output logic rxd,
  output logic cts_n
);
  logic [7:0] got [$];
  logic [7:0] b;
  initial begin
    rxd = 1'b1;
    cts_n = 1'b1;
  end
  always begin : rx_frames
    @(negedge txd);
    repeat (BIT / 2) @(posedge aclk);
    for (int i = 0; i < 8; i++) begin
      repeat (BIT) @(posedge aclk);
      b[i] = txd;
    end
    repeat (BIT) @(posedge aclk);
    got.push_back(b);
  end
  task automatic send(input logic [7:0] c);
    logic [9:0] f;
    f = {1'b1, c, 1'b0};
    for (int i = 0; i < 10; i++) begin
      rxd <= f[i];
      repeat (BIT) @(posedge aclk);
    end
  endtask : send
endmodule : printer_model
`default_nettype wire

// file: testbench.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin errors++; \
  $display("BAD %0t %h %h", $time, a, b); end end
module testbench;
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, backup_ok;
  logic awready, wready, bvalid, arready, rvalid, txd, rxd, cts_n, rts_n;
  logic [7:0] awaddr, araddr, r1, r2;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp;
  logic [7:0] e [$];
  int errors, total_checks;
  printer_serial_output #(.CLK_HZ(192000)) DUT (.*);
  printer_model printer (.*);
  function automatic logic [7:0] asc(input logic [3:0] n);
    return (n < 4'hA) ? 8'h30 + 8'(n) : 8'h37 + 8'(n);
  endfunction : asc
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] x);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    bready <= 1'b1;
    @(posedge aclk);
    `CHK(bresp, x)
    bready <= 1'b0;
    @(posedge aclk);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] x);
    araddr <= a;
    arvalid <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    rready <= 1'b1;
    @(posedge aclk);
    `CHK(rdata, x)
    rready <= 1'b0;
    @(posedge aclk);
  endtask : rd
  task automatic txt(input logic [8:0] c);
    wr(printer_pkg::ADDR_TEXT, {23'h0, c}, printer_pkg::RESP_OKAY);
  endtask : txt
  task automatic expect_out;
    for (int i = 0; i < 3000 && printer.got.size() < e.size(); i++) @(posedge aclk);
    `CHK(printer.got.size(), e.size())
    foreach (e[i]) `CHK(printer.got[i], e[i])
    printer.got.delete();
    e.delete();
  endtask : expect_out
  task automatic end_of_test;
    if (errors == 0 && total_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : end_of_test
  initial begin
    aclk = 1'b0;
    forever #12.5 aclk = ~aclk;
  end
  initial begin : watchdog
    repeat (20000) @(posedge aclk);
    errors++;
    end_of_test();
  end
  initial begin : main
    {aresetn, awvalid, wvalid, bready, arvalid, rready, backup_ok} = '0;
    {awaddr, araddr, wdata} = '0;
    wstrb = 4'hF;
    errors = 0;
    total_checks = 0;
    void'($urandom(32286));
    r1 = 8'($urandom);
    r2 = 8'($urandom);
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    backup_ok <= 1'b1;
    @(posedge aclk);
    rd(printer_pkg::ADDR_CONFIG, 32'h00D);
    rd(8'h40, 32'h0);
    wr(8'h40, 32'h1, printer_pkg::RESP_SLVERR);
    wr(printer_pkg::ADDR_CONTROL, 32'h1, printer_pkg::RESP_OKAY);
    txt(9'h041);
    txt(9'h15A);
    txt(9'h00A);
    repeat (300) @(posedge aclk);
    `CHK(printer.got.size(), 0)
    printer.cts_n <= 1'b0;
    e = '{8'h41, 8'h0D, 8'h0A};
    expect_out();
    txt(9'h024);
    txt({1'b0, asc(r1[7:4])});
    txt({1'b0, asc(r1[3:0])});
    txt(9'h00A);
    e = '{r1, 8'h0D, 8'h0A};
    expect_out();
    wr(printer_pkg::ADDR_SEQ_LEN, 32'h0, printer_pkg::RESP_OKAY);
    wr(printer_pkg::ADDR_SEQ_DATA, {12'h0, 4'h3, 8'h0, r2}, printer_pkg::RESP_OKAY);
    wr(printer_pkg::ADDR_SEQ_LEN, 32'h30001, printer_pkg::RESP_OKAY);
    txt(9'h023);
    txt(9'h033);
    txt(9'h00A);
    e = '{r2};
    expect_out();
    wr(printer_pkg::ADDR_CONFIG, 32'h10D, printer_pkg::RESP_OKAY);
    wr(printer_pkg::ADDR_CONTROL, 32'h1, printer_pkg::RESP_OKAY);
    txt(9'h042);
    txt(9'h00A);
    repeat (300) @(posedge aclk);
    `CHK(printer.got.size(), 0)
    printer.send(printer_pkg::CH_XON);
    e = '{8'h42};
    expect_out();
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd(printer_pkg::ADDR_CONFIG, 32'h10D);
    end_of_test();
  end
endmodule : testbench
`default_nettype wire
